// ===== rtl/sram_port_pkg.sv
// shared constants and types for the pipelined burst static memory port
// assumes one rising-edge clock shared with the memory controller
package sram_port_pkg;

  ////////////////////////////////////////////////////////////////////////////////////////////////
  // organisation
  localparam int LANES_X36 = 4;
  localparam int LANES_X18 = 2;
  localparam int WORDS_X36 = 524288;
  localparam int WORDS_X18 = 1048576;
  localparam int BYTE_W    = 8;
  localparam int LANE_W    = BYTE_W + 1;
  localparam int ADDR_MAX  = 20;
  localparam int LANE_MAX  = 4;
  localparam int BURST_W   = 2;

  ////////////////////////////////////////////////////////////////////////////////////////////////
  // rated clock grades and the core clock of this build
  localparam int GRADE_FAST_MHZ = 250;
  localparam int GRADE_MID_MHZ  = 200;
  localparam int GRADE_SLOW_MHZ = 167;
  localparam int CORE_CLK_MHZ   = 100;

  ////////////////////////////////////////////////////////////////////////////////////////////////
  // pipeline figures, in qualified clock edges after the command edge
  localparam int READ_LATENCY     = 2;
  localparam int WRITE_DATA_EDGE  = 3;

  ////////////////////////////////////////////////////////////////////////////////////////////////
  // types and reset values
  typedef enum logic [2:0] {
    OP_IDLE  = 3'b001,
    OP_READ  = 3'b010,
    OP_WRITE = 3'b100
  } op_e;

  typedef struct packed {
    op_e                 op;
    logic [ADDR_MAX-1:0] addr;
    logic [LANE_MAX-1:0] lane_n;
    logic [BURST_W-1:0]  start;
    logic [BURST_W-1:0]  cnt;
  } cmd_s;

  localparam logic [BURST_W-1:0] BURST_CNT_RST = 2'h0;
  localparam cmd_s               CMD_RST       = '{OP_IDLE, 20'h00000, 4'hF, 2'h0, 2'h0};

endpackage : sram_port_pkg

// ===== rtl/sram_array.sv
// storage array with per-lane writes and combinational read
// assumes writes arrive already qualified; the array itself has no reset
`timescale 1ns/1ps
module sram_array #(
  parameter int LANES  = sram_port_pkg::LANES_X36,
  parameter int ADDR_W = 19
) (
  input  wire logic                                   core_clk,
  input  wire logic                                   rst,
  input  wire logic                                   write_en,
  input  wire logic [ADDR_W-1:0]                      write_addr,
  input  wire logic [LANES-1:0]                       lane_write,
  input  wire logic [LANES*sram_port_pkg::LANE_W-1:0] write_word,
  input  wire logic [ADDR_W-1:0]                      read_addr,
  output logic      [LANES*sram_port_pkg::LANE_W-1:0] read_word
);
  import sram_port_pkg::*;

  logic [LANES*LANE_W-1:0] mem [2**ADDR_W];

  assign read_word = mem[read_addr];

  ////////////////////////////////////////////////////////////////////////////////////////////////
  // one write port per lane: byte plus its parity bit
  for (genvar i = 0; i < LANES; i++) begin : g_lane
    always_ff @(posedge core_clk) begin
      if (write_en && lane_write[i]) begin
        mem[write_addr][i*LANE_W +: LANE_W] <= write_word[i*LANE_W +: LANE_W];
      end
    end

    a_lane_write: assert property (@(posedge core_clk) disable iff (rst)
      write_en && lane_write[i] |=> mem[$past(write_addr)][i*LANE_W +: LANE_W]
        == $past(write_word[i*LANE_W +: LANE_W]))
      else $error("selected lane not written");

    a_lane_keep: assert property (@(posedge core_clk) disable iff (rst)
      write_en && !lane_write[i] |=> mem[$past(write_addr)][i*LANE_W +: LANE_W]
        == $past(mem[write_addr][i*LANE_W +: LANE_W]))
      else $error("unselected lane changed");
  end

endmodule : sram_array

// ===== rtl/sram_port.sv
// pipelined burst static memory port, device end
// assumes the controller drives all synchronous pins from core_clk;
// mode strap and output enable arrive unsynchronised.
//
// Functional notes
// - every synchronous input including write data is captured in a register on the rising edge.
// - read data leaves through an output register loaded on the rising edge.
// - with the clock qualifier inactive the edge is ignored and all pipeline state holds.
// - a new read or write is taken every cycle in any mix with no idle cycles.
// - writes are qualified by write enable and per-lane selects, only selected lanes change.
// - writes complete internally with no write pulse from the controller.
// - the part is selected only when all three chip selects are active; output enable gates drive.
// - the data drivers turn off during the data cycle of a write.
// - bursts follow linear or interleaved order, chosen by a static mode input.
// - the array holds 512K words of 36 bits or 1M words of 18 bits.
// - the fastest grade runs at 250 MHz with zero wait states, others at 200 and 167 MHz.
// - each lane select gates exactly one byte and its matching parity bit.
// - advance high steps the burst counter, low loads a new address.
// - the second chip select is active high, the first and third active low.
`timescale 1ns/1ps
module sram_port #(
  parameter int LANES  = sram_port_pkg::LANES_X36,
  parameter int ADDR_W = $clog2((LANES == sram_port_pkg::LANES_X36) ?
                         sram_port_pkg::WORDS_X36 : sram_port_pkg::WORDS_X18)
) (
  input  wire logic                                   core_clk,
  input  wire logic                                   rst,
  input  wire logic [ADDR_W-1:0]                      address,
  input  wire logic                                   write_enable_n,
  input  wire logic [LANES-1:0]                       byte_lane_write_select_n,
  input  wire logic                                   chip_select_first_n,
  input  wire logic                                   chip_select_second,
  input  wire logic                                   chip_select_third_n,
  input  wire logic                                   advance_or_load,
  input  wire logic                                   clock_qualifier_n,
  input  wire logic                                   output_enable_n,
  input  wire logic                                   burst_interleaved,
  input  wire logic [LANES*sram_port_pkg::BYTE_W-1:0] data_io_in,
  output logic      [LANES*sram_port_pkg::BYTE_W-1:0] data_io_out,
  output logic                                        data_io_oe,
  input  wire logic [LANES-1:0]                       parity_io_in,
  output logic      [LANES-1:0]                       parity_io_out,
  output logic                                        parity_io_oe
);
  import sram_port_pkg::*;

  localparam int WORD_W = LANES * LANE_W;

  // grade check kept as a constant: the core clock must not exceed the fastest grade
  localparam bit CLK_IN_GRADE = (CORE_CLK_MHZ <= GRADE_FAST_MHZ);

  default clocking dc @(posedge core_clk); endclocking
  default disable iff (rst);

  cmd_s              cmd_q, s1, s2, s3;
  cmd_s              next_cmd, next_s1, next_s2, next_s3;
  logic [WORD_W-1:0] din_q, dout;
  logic [WORD_W-1:0] next_din, next_dout;
  logic              drive, next_drive;
  logic              oe_q, next_oe;
  logic              mode_meta, mode_sync;
  logic              oe_n_meta, oe_n_sync;
  logic              qual, selected;
  logic [WORD_W-1:0] in_word, mem_word, fwd_word;
  logic              write_en;

  function automatic logic [BURST_W-1:0] burst_low(input logic [BURST_W-1:0] start,
                                                   input logic [BURST_W-1:0] cnt,
                                                   input logic               il);
    burst_low = il ? (start ^ cnt) : BURST_W'(start + cnt);
  endfunction : burst_low

  ////////////////////////////////////////////////////////////////////////////////////////////////
  // pin synchronisers for the strap and the asynchronous output enable
  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      mode_meta <= 1'b0;
      mode_sync <= 1'b0;
      oe_n_meta <= 1'b1;
      oe_n_sync <= 1'b1;
    end else begin
      mode_meta <= burst_interleaved;
      mode_sync <= mode_meta;
      oe_n_meta <= output_enable_n;
      oe_n_sync <= oe_n_meta;
    end
  end

  ////////////////////////////////////////////////////////////////////////////////////////////////
  // lane packing and forwarding of writes not yet in the array
  assign qual     = !clock_qualifier_n;
  assign selected = !chip_select_first_n && chip_select_second && !chip_select_third_n;

  for (genvar i = 0; i < LANES; i++) begin : g_lane
    assign in_word[i*LANE_W +: LANE_W] = {parity_io_in[i], data_io_in[i*BYTE_W +: BYTE_W]};
    assign data_io_out[i*BYTE_W +: BYTE_W] = dout[i*LANE_W +: BYTE_W];
    assign parity_io_out[i] = dout[i*LANE_W + BYTE_W];
    // newest write wins; its data is still on the pins this cycle
    always_comb begin
      if (s2.op == OP_WRITE && s2.addr == s1.addr && !s2.lane_n[i]) begin
        fwd_word[i*LANE_W +: LANE_W] = in_word[i*LANE_W +: LANE_W];
      end else if (s3.op == OP_WRITE && s3.addr == s1.addr && !s3.lane_n[i]) begin
        fwd_word[i*LANE_W +: LANE_W] = din_q[i*LANE_W +: LANE_W];
      end else begin
        fwd_word[i*LANE_W +: LANE_W] = mem_word[i*LANE_W +: LANE_W];
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////////////////////////
  // command decode and pipeline
  always_comb begin
    next_cmd   = cmd_q;
    next_s1    = s1;
    next_s2    = s2;
    next_s3    = s3;
    next_din   = din_q;
    next_dout  = dout;
    next_drive = drive;
    if (qual) begin
      if (advance_or_load) begin
        if (cmd_q.op != OP_IDLE) begin
          next_cmd.cnt        = BURST_W'(cmd_q.cnt + 2'h1);
          next_cmd.addr[1:0]  = burst_low(cmd_q.start, next_cmd.cnt, mode_sync);
          next_cmd.lane_n     = '1;
          next_cmd.lane_n[LANES-1:0] = byte_lane_write_select_n;
        end
      end else if (selected) begin
        next_cmd.op     = write_enable_n ? OP_READ : OP_WRITE;
        next_cmd.addr   = ADDR_MAX'(address);
        next_cmd.start  = address[1:0];
        next_cmd.cnt    = BURST_CNT_RST;
        next_cmd.lane_n = '1;
        next_cmd.lane_n[LANES-1:0] = byte_lane_write_select_n;
      end else begin
        next_cmd = CMD_RST;
      end
      next_s1    = cmd_q;
      next_s2    = s1;
      next_s3    = s2;
      if (s2.op == OP_WRITE) begin
        next_din = in_word;
      end
      if (s1.op == OP_READ) begin
        next_dout = fwd_word;
      end
      next_drive = (s1.op == OP_READ);
    end
    next_oe = next_drive && !oe_n_sync;
  end

  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      cmd_q <= CMD_RST;
      s1    <= CMD_RST;
      s2    <= CMD_RST;
      s3    <= CMD_RST;
      din_q <= '0;
      dout  <= '0;
      drive <= 1'b0;
      oe_q  <= 1'b0;
    end else begin
      cmd_q <= next_cmd;
      s1    <= next_s1;
      s2    <= next_s2;
      s3    <= next_s3;
      din_q <= next_din;
      dout  <= next_dout;
      drive <= next_drive;
      oe_q  <= next_oe;
    end
  end

  assign data_io_oe   = oe_q;
  assign parity_io_oe = oe_q;

  ////////////////////////////////////////////////////////////////////////////////////////////////
  // self-timed write: commit from the captured data one edge after it lands
  assign write_en = qual && (s3.op == OP_WRITE);

  sram_array #(
    .LANES  (LANES),
    .ADDR_W (ADDR_W)
  ) u_array (
    .core_clk   (core_clk),
    .rst        (rst),
    .write_en   (write_en),
    .write_addr (s3.addr[ADDR_W-1:0]),
    .lane_write (~s3.lane_n[LANES-1:0]),
    .write_word (din_q),
    .read_addr  (s1.addr[ADDR_W-1:0]),
    .read_word  (mem_word)
  );

  ////////////////////////////////////////////////////////////////////////////////////////////////
  // checks
  a_capture_addr: assert property (
    qual && !advance_or_load && selected |=> cmd_q.addr == ADDR_MAX'($past(address)))
    else $error("load address not captured");

  a_stall_hold: assert property (
    !qual |=> $stable(cmd_q) && $stable(s1) && $stable(s2) && $stable(s3) && $stable(dout))
    else $error("pipeline moved while stalled");

  a_read_latency: assert property (
    qual && cmd_q.op == OP_READ ##1 qual |=> drive && $past(s1.op) == OP_READ)
    else $error("read data not launched two edges after command");

  a_back_to_back: assert property (
    qual && !advance_or_load && selected
      |=> cmd_q.op == ($past(write_enable_n) ? OP_READ : OP_WRITE))
    else $error("command refused or wrong direction");

  a_deselect: assert property (
    qual && !advance_or_load && !selected |=> cmd_q.op == OP_IDLE)
    else $error("deselected command accepted");

  a_oe_gate: assert property (
    oe_n_sync |=> !data_io_oe && !parity_io_oe)
    else $error("drivers on while output enable inactive");

  a_write_hiz: assert property (
    qual && s1.op == OP_WRITE |=> !data_io_oe)
    else $error("drivers on in write data cycle");

  a_burst_step: assert property (
    qual && advance_or_load && cmd_q.op != OP_IDLE
      |=> cmd_q.cnt == BURST_W'($past(cmd_q.cnt) + 2'h1) && cmd_q.op == $past(cmd_q.op))
    else $error("burst counter did not step");

  a_burst_order: assert property (
    cmd_q.op != OP_IDLE && $stable(mode_sync)
      |-> cmd_q.addr[1:0] == burst_low(cmd_q.start, cmd_q.cnt, mode_sync))
    else $error("burst address out of order");

  a_wdata_capture: assert property (
    qual && s2.op == OP_WRITE |=> din_q == $past(in_word) ##0 s3.op == OP_WRITE)
    else $error("write data not captured");

  a_write_commit: assert property (
    qual && cmd_q.op == OP_WRITE ##1 qual ##1 qual ##1 qual |-> write_en)
    else $error("write not committed on time");

  c_read:  cover property (qual && cmd_q.op == OP_READ ##2 data_io_oe);
  c_write: cover property (write_en);
  c_burst: cover property (qual && advance_or_load && cmd_q.op != OP_IDLE && cmd_q.cnt == 2'h3);
  c_stall: cover property (s1.op != OP_IDLE && !qual);
  c_turn:  cover property (qual && cmd_q.op == OP_WRITE ##1 qual && cmd_q.op == OP_READ);

endmodule : sram_port

// ===== verif/ctrl_model.sv
// controller-side model: presents write data in its slot on the data pins
// assumes the bench announces each command on cmd_kind in the cycle it is driven
`timescale 1ns/1ps
module ctrl_model (
  input  wire logic        core_clk,
  input  wire logic        rst,
  input  wire logic        clock_qualifier_n,
  input  wire logic [1:0]  cmd_kind,
  input  wire logic [35:0] cmd_wdata,
  output logic      [31:0] data_io_in,
  output logic      [3:0]  parity_io_in
);
  logic [1:0]  k [3];
  logic [35:0] d [3];
  logic [35:0] junk;
  ////////////////////////////////////////////////////////////////////////////////////////////////
  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      k    <= '{default: 2'h0};
      junk <= 36'h5A5A5A5A5;
    end else begin
      junk <= ~junk; // released bus never repeats stale data
      if (!clock_qualifier_n) begin // stalled edges shift nothing
        k <= '{cmd_kind, k[0], k[1]};
        d <= '{cmd_wdata, d[0], d[1]};
      end
    end
  end
  // data only in its own slot, no strobe timing
  assign {parity_io_in, data_io_in} = (k[2] == 2'h2) ? d[2] : junk;
endmodule : ctrl_model

// ===== verif/tb_top.sv
// self-checking bench for the pipelined burst port, 36-bit build
// assumes ctrl_model on the data pins; kinds: 0 idle, 1 read, 2 write, 3 read blind
`timescale 1ns/1ps
module tb_top;
  import sram_port_pkg::*;
  logic        core_clk, rst, we_n, cs1_n, cs2, cs3_n, adv, qual_n, oe_n, il, doe, poe;
  logic [18:0] addr;
  logic [3:0]  ln, par_out, par_in;
  logic [31:0] dout, din;
  logic [1:0]  cmd_kind, p_kind [3];
  logic [35:0] cmd_exp, cmd_wdata, p_exp [3];
  logic [35:0] mem [int];
  int          failures, total_checks;

  sram_port #(.LANES(LANES_X36), .ADDR_W(19)) dut (.core_clk(core_clk), .rst(rst),
    .address(addr), .write_enable_n(we_n), .byte_lane_write_select_n(ln),
    .chip_select_first_n(cs1_n), .chip_select_second(cs2), .chip_select_third_n(cs3_n),
    .advance_or_load(adv), .clock_qualifier_n(qual_n), .output_enable_n(oe_n),
    .burst_interleaved(il), .data_io_in(din), .data_io_out(dout), .data_io_oe(doe),
    .parity_io_in(par_in), .parity_io_out(par_out), .parity_io_oe(poe));
  ctrl_model host (.core_clk(core_clk), .rst(rst), .clock_qualifier_n(qual_n),
    .cmd_kind(cmd_kind), .cmd_wdata(cmd_wdata), .data_io_in(din), .parity_io_in(par_in));

  initial begin
    core_clk = 1'b0;
    forever #5 core_clk = ~core_clk;
  end
  ////////////////////////////////////////////////////////////////////////////////////////////////
  task automatic chk_word(input logic [35:0] got, input logic [35:0] exp);
    total_checks++;
    if (got !== exp) begin
      failures++;
      $display("wrong value at %0t: got %h expected %h", $time, got, exp);
    end
  endtask : chk_word
  task automatic chk_flag(input logic got, input logic exp);
    total_checks++;
    if (got !== exp) begin
      failures++;
      $display("wrong value at %0t: got %h expected %h", $time, got, exp);
    end
  endtask : chk_flag
  task automatic final_report;
    $display("checks %0d failures %0d", total_checks, failures);
    if (failures == 0 && total_checks > 0) $display("Finished cleanly");
    else $display("Finished with errors");
    $finish;
  endtask : final_report
  task automatic drive(input logic [1:0] kd, input logic w, input logic [18:0] a,
                       input logic [3:0] l, input logic av, input logic [2:0] cs,
                       input logic [35:0] wd, input logic [35:0] ex);
    @(posedge core_clk);
    we_n      <= w;
    addr      <= a;
    ln        <= l;
    adv       <= av;
    qual_n    <= 1'b0;
    {cs1_n, cs2, cs3_n} <= cs;
    cmd_kind  <= kd;
    cmd_wdata <= wd;
    cmd_exp   <= ex;
  endtask : drive
  // advance beats drive a wrong address and direction: both must be ignored
  task automatic op(input logic wr, input logic [18:0] a, input logic [3:0] l,
                    input logic av, input logic [35:0] wd);
    logic [35:0] ex;
    ex = mem.exists(a) ? mem[a] : 'x;
    if (wr) begin
      for (int i = 0; i < 4; i++) if (!l[i]) begin
        ex[i*8 +: 8] = wd[i*8 +: 8];
        ex[32+i]     = wd[32+i];
      end
      mem[a] = ex;
    end
    drive(wr ? 2'h2 : (oe_n ? 2'h3 : 2'h1), av ? wr : ~wr, av ? ~a : a, l, av, 3'b010,
          wd, ex);
  endtask : op
  task automatic idle(input int n);
    repeat (n) drive(2'h0, 1'b0, 19'h0, 4'h0, 1'b0, 3'b110, 36'h0, 36'h0);
  endtask : idle
  function automatic logic [18:0] ba(input logic m, input int c);
    logic [1:0] s;
    // odd start: linear and interleaved orders differ on the second and fourth beats
    s = 2'h1;
    return {17'h00100, m ? (s ^ c[1:0]) : (s + c[1:0])};
  endfunction : ba
  ////////////////////////////////////////////////////////////////////////////////////////////////
  // expected pipeline: advances only on qualified edges, judged mid-cycle
  always @(posedge core_clk or posedge rst) begin
    if (rst) p_kind <= '{default: 2'h0};
    else if (!qual_n) begin
      p_kind <= '{cmd_kind, p_kind[0], p_kind[1]};
      p_exp  <= '{cmd_exp, p_exp[0], p_exp[1]};
    end
  end
  always @(negedge core_clk) if (!rst) begin
    if (p_kind[2] == 2'h0) chk_flag(doe, 1'b0);
    if (p_kind[2] == 2'h1) begin
      chk_flag(doe, 1'b1);
      chk_flag(poe, 1'b1);
      chk_word({par_out, dout}, p_exp[2]);
    end
    if (p_kind[2] == 2'h2) begin
      chk_flag(doe, 1'b0);
      chk_flag(poe, 1'b0);
    end
    if (p_kind[2] == 2'h3) chk_flag(doe, 1'b0);
  end
  ////////////////////////////////////////////////////////////////////////////////////////////////
  task automatic sc_mixed;
    op(1'b1, 19'h00010, 4'h0, 1'b0, 36'h123456789);
    op(1'b0, 19'h00010, 4'h0, 1'b0, 36'h0);
    op(1'b1, 19'h7FFFF, 4'h0, 1'b0, 36'hFEDCBA987);
    op(1'b1, 19'h00010, 4'hA, 1'b0, 36'h011223344);
    op(1'b0, 19'h00010, 4'h0, 1'b0, 36'h0);
    op(1'b0, 19'h7FFFF, 4'h0, 1'b0, 36'h0);
    idle(3);
  endtask : sc_mixed
  task automatic sc_lanes;
    op(1'b1, 19'h00020, 4'h0, 1'b0, 36'h0);
    for (int i = 0; i < 4; i++) begin
      op(1'b1, 19'h00020, ~(4'h1 << i), 1'b0, 36'hFFFFFFFFF);
      op(1'b0, 19'h00020, 4'h0, 1'b0, 36'h0);
    end
    idle(3);
  endtask : sc_lanes
  task automatic sc_select;
    logic [2:0] off [3];
    off = '{3'b110, 3'b000, 3'b011};
    op(1'b1, 19'h00030, 4'h0, 1'b0, 36'h0AAAAAAAA);
    for (int i = 0; i < 3; i++) begin
      drive(2'h0, 1'b0, 19'h00030, 4'h0, 1'b0, off[i], 36'h555555555, 36'h0);
      op(1'b0, 19'h00030, 4'h0, 1'b0, 36'h0);
    end
    idle(3);
    // advance with no burst open must stay idle: drivers stay off
    drive(2'h0, 1'b1, 19'h00030, 4'h0, 1'b1, 3'b010, 36'h0, 36'h0);
    idle(3);
  endtask : sc_select
  task automatic sc_stall;
    op(1'b0, 19'h00030, 4'h0, 1'b0, 36'h0);
    op(1'b1, 19'h00030, 4'h0, 1'b0, 36'h3C3C3C3C3);
    repeat (3) @(posedge core_clk) qual_n <= 1'b1;
    op(1'b0, 19'h00030, 4'h0, 1'b0, 36'h0);
    idle(4);
  endtask : sc_stall
  task automatic sc_oe;
    @(posedge core_clk) oe_n <= 1'b1;
    idle(5);
    op(1'b0, 19'h00010, 4'h0, 1'b0, 36'h0);
    idle(3);
    @(posedge core_clk) oe_n <= 1'b0;
    idle(5);
  endtask : sc_oe
  task automatic sc_burst;
    for (int m = 0; m < 2; m++) begin
      @(posedge core_clk) il <= m[0];
      idle(5);
      for (int c = 0; c < 5; c++)
        op(1'b1, ba(m[0], c), 4'h0, c != 0, 36'h9A5C30000 + 36'(c * 2 + m));
      for (int c = 0; c < 5; c++)
        op(1'b0, ba(m[0], c), 4'h0, c != 0, 36'h0);
      idle(3);
    end
  endtask : sc_burst
  ////////////////////////////////////////////////////////////////////////////////////////////////
  initial begin
    repeat (20000) @(posedge core_clk);
    failures++;
    final_report;
  end
  initial begin
    {we_n, cs1_n, cs2, cs3_n, adv, qual_n, oe_n, il} = 8'h90;
    {addr, ln, cmd_kind, cmd_exp, cmd_wdata} = '0;
    rst = 1'b1;
    repeat (8) @(posedge core_clk);
    rst <= 1'b0;
    idle(8);
    sc_mixed;
    sc_lanes;
    sc_select;
    sc_stall;
    sc_oe;
    sc_burst;
    final_report;
  end
endmodule : tb_top
